//--- rtl/dtmf_remote_command_parser.sv
/*
  remote command parser: key codes in, configuration state and ok request out.
  assumes the key decoder pins and carrier input are asynchronous; the stored
  settings are held in flops here and retained by the system around them.
*/
module dtmf_remote_command_parser
  import remote_cmd_pkg::*;
#(
  parameter int unsigned GAP_LIMIT = GAP_CYCLES,
  parameter int unsigned PULSE_LEN = PULSE_CYCLES,
  parameter logic [11:0] PASSWORD = 12'h987
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // key decoder
  input wire logic [3:0] i_key_code,
  input wire logic i_key_valid,
  // receiver carrier
  input wire logic i_carrier,
  // ok handshake with the morse sender
  input wire logic i_ok_done,
  output logic o_ok_req,
  // function 00 state
  output logic o_main_tx_inhibit,
  output logic o_link_tx_inhibit,
  output logic o_timeout_disable,
  output logic o_roger_suppress,
  output logic o_extra_tail_beeps,
  output logic o_sec_port_pulse,
  // stored options
  output port_opts_t o_port_opts,
  output logic o_sec_tail_callsign,
  output relay_opts_t o_relay_opts,
  output tone_opts_t o_tone_opts,
  output timers_t o_timers,
  // callsign and message string bytes
  output logic [7:0] o_str_byte,
  output logic o_str_callsign,
  output logic o_str_valid,
  output logic o_str_end
);

  typedef enum {
    S_IDLE, S_PASS, S_FN_HI, S_FN_LO, S_DAT_HI, S_DAT_LO
  } parse_state_t;

  parse_state_t state_ff;
  logic [3:0] code_s1_ff, code_s2_ff;
  logic [2:0] valid_sync_ff;
  logic [1:0] car_sync_ff;
  logic [1:0] pass_idx_ff;
  logic [3:0] hi_ff;
  logic [7:0] fn_ff;
  logic [31:0] gap_ff;
  logic [31:0] pulse_ff;
  logic pending_ff;
  logic [7:0] port_raw_ff, relay_raw_ff, tone_raw_ff;
  logic [2:0] f00_ff;
  logic [7:0] str_byte_ff;
  logic str_valid_ff, str_end_ff, str_call_ff;
  logic [3:0] digit;
  logic strobe;
  logic [7:0] byte_val;
  logic range_ok;
  logic accept;
  logic carrier;

  // synchronise the decoder pins; code is stable while the strobe is high
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      code_s1_ff <= 4'h0;
      code_s2_ff <= 4'h0;
      valid_sync_ff <= 3'h0;
      car_sync_ff <= 2'h0;
    end else begin
      code_s1_ff <= i_key_code;
      code_s2_ff <= code_s1_ff;
      valid_sync_ff <= {valid_sync_ff[1:0], i_key_valid};
      car_sync_ff <= {car_sync_ff[0], i_carrier};
    end
  end

  // rising edge of the synced strobe: a held key yields one digit only
  assign strobe = valid_sync_ff[1] & ~valid_sync_ff[2];
  assign carrier = car_sync_ff[1];

  // decoder code to key value; star arrives as b and hash as c
  always_comb begin
    case (code_s2_ff)
      4'ha: digit = 4'h0;
      4'hd: digit = 4'ha;
      4'he: digit = 4'hb;
      4'hf: digit = 4'hc;
      4'h0: digit = 4'hd;
      4'hb: digit = 4'he;
      4'hc: digit = 4'hf;
      default: digit = code_s2_ff;
    endcase
  end

  // the high nibble is always the earlier digit
  assign byte_val = {hi_ff, digit};

  // per-function data limits; an unknown address never accepts
  always_comb begin
    case (fn_ff)
      FN_TXCTL: range_ok = (byte_val <= 8'h04);
      FN_PORT, FN_RELAY, FN_CTCSS: range_ok = (byte_val <= 8'h7f);
      FN_CTDLY, FN_CALLINT, FN_TIMEOUT, FN_MSGINT: range_ok = (byte_val <= MAX_MINS);
      FN_MUTEDLY: range_ok = 1'b1;
      FN_TAIL: range_ok = (byte_val <= MAX_TAIL);
      FN_POSTTAIL, FN_SPEED: range_ok = (byte_val <= MAX_SPEED);
      FN_FREQ: range_ok = (byte_val >= MIN_FREQ) && (byte_val <= MAX_FREQ);
      FN_VMAIN, FN_VLINK: range_ok = (byte_val >= MIN_VOLT) && (byte_val <= MAX_VOLT);
      FN_CALLSIGN, FN_MESSAGE: range_ok = 1'b1;
      default: range_ok = 1'b0;
    endcase
  end

  // a complete, in-range data pair on a plain function
  assign accept = strobe && (state_ff == S_DAT_LO) && range_ok &&
                  (fn_ff != FN_CALLSIGN) && (fn_ff != FN_MESSAGE) &&
                  (fn_ff != FN_CLRPERM);

  // the password is a build-time constant, never written over the link
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_ff <= S_IDLE;
      pass_idx_ff <= 2'h0;
      hi_ff <= 4'h0;
      fn_ff <= 8'h00;
    end else if (state_ff != S_IDLE && !strobe && gap_ff >= GAP_LIMIT) begin
      state_ff <= S_IDLE;
    end else if (strobe) begin
      case (state_ff)
        S_IDLE: begin
          if (digit == DIG_STAR) begin
            state_ff <= S_PASS;
            pass_idx_ff <= 2'h0;
          end
        end
        S_PASS: begin
          if (digit != PASSWORD[4'(11 - 4 * pass_idx_ff) -: 4]) begin
            state_ff <= S_IDLE;
          end else if (pass_idx_ff == 2'(PASS_LEN - 1)) begin
            state_ff <= S_FN_HI;
          end else begin
            pass_idx_ff <= pass_idx_ff + 2'h1;
          end
        end
        S_FN_HI: begin
          hi_ff <= digit;
          state_ff <= S_FN_LO;
        end
        S_FN_LO: begin
          fn_ff <= byte_val;
          state_ff <= S_DAT_HI;
        end
        S_DAT_HI: begin
          hi_ff <= digit;
          if (digit == DIG_STAR && fn_ff == FN_TXCTL) begin
            state_ff <= S_IDLE;
          end else begin
            state_ff <= S_DAT_LO;
          end
        end
        S_DAT_LO: begin
          if ((fn_ff == FN_CALLSIGN || fn_ff == FN_MESSAGE) && byte_val != STR_END) begin
            state_ff <= S_DAT_HI;
          end else begin
            state_ff <= S_IDLE;
          end
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      gap_ff <= 32'h0;
    end else if (strobe || state_ff == S_IDLE) begin
      gap_ff <= 32'h0;
    end else if (gap_ff < GAP_LIMIT) begin
      // saturates so a long silence cannot wrap back under the limit
      gap_ff <= gap_ff + 32'h1;
    end
  end

  // function 00: bit0 main+link, bit1 link, bit2 timer; volatile by reset
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      f00_ff <= 3'h0;
    end else if (strobe && state_ff == S_DAT_HI && digit == DIG_STAR &&
                 fn_ff == FN_TXCTL) begin
      f00_ff <= 3'h0;
    end else if (strobe && state_ff == S_DAT_LO && fn_ff == FN_CLRPERM &&
                 hi_ff == 4'h0 && digit == DIG_STAR) begin
      f00_ff <= 3'h0;
    end else if (accept && fn_ff == FN_TXCTL) begin
      case (byte_val[2:0])
        3'h0: f00_ff <= 3'h0;
        3'h1: f00_ff[0] <= 1'b1;
        3'h2: f00_ff[1] <= 1'b1;
        3'h3: f00_ff[2] <= 1'b1;
        default: f00_ff <= f00_ff;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pulse_ff <= 32'h0;
    end else if (accept && fn_ff == FN_TXCTL && byte_val == 8'h04) begin
      // a repeated 00/04 restarts the full pulse
      pulse_ff <= PULSE_LEN;
    end else if (pulse_ff != 32'h0) begin
      pulse_ff <= pulse_ff - 32'h1;
    end
  end

  // option bytes: whole byte replaced on each write
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      port_raw_ff <= RST_OPT;
      relay_raw_ff <= RST_OPT;
      tone_raw_ff <= RST_OPT;
    end else if (accept) begin
      if (fn_ff == FN_PORT) port_raw_ff <= byte_val;
      if (fn_ff == FN_RELAY) relay_raw_ff <= byte_val;
      if (fn_ff == FN_CTCSS) tone_raw_ff <= byte_val;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_timers <= '{RST_CTDLY, RST_MUTEDLY, RST_CALLINT, RST_TIMEOUT, RST_TAIL,
                    RST_MSGINT, RST_POSTTAIL, RST_SPEED, RST_FREQ, RST_VMAIN,
                    RST_VLINK};
    end else if (accept) begin
      // only an in-range accept writes, so a refused value keeps the old one
      case (fn_ff)
        FN_CTDLY: o_timers.ctcss_delay <= byte_val;
        FN_MUTEDLY: o_timers.mute_delay <= byte_val;
        FN_CALLINT: o_timers.call_interval <= byte_val;
        FN_TIMEOUT: o_timers.timeout_mins <= byte_val;
        FN_TAIL: o_timers.tail_tenths <= byte_val;
        FN_MSGINT: o_timers.msg_interval <= byte_val;
        FN_POSTTAIL: o_timers.post_tail <= byte_val;
        FN_SPEED: o_timers.morse_speed <= byte_val;
        FN_FREQ: o_timers.morse_freq <= byte_val;
        FN_VMAIN: o_timers.volt_main <= byte_val;
        FN_VLINK: o_timers.volt_link <= byte_val;
        default: o_timers <= o_timers;
      endcase
    end
  end

  // string bytes, ff included as the terminator
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      str_byte_ff <= 8'h00;
      str_valid_ff <= 1'b0;
      str_end_ff <= 1'b0;
      str_call_ff <= 1'b0;
    end else begin
      // valid and end are one-cycle strobes; the byte and kind hold
      str_valid_ff <= 1'b0;
      str_end_ff <= 1'b0;
      if (strobe && state_ff == S_DAT_LO && (fn_ff == FN_CALLSIGN || fn_ff == FN_MESSAGE)) begin
        str_byte_ff <= byte_val;
        str_valid_ff <= 1'b1;
        str_end_ff <= (byte_val == STR_END);
        str_call_ff <= (fn_ff == FN_CALLSIGN);
      end
    end
  end

  // ok waits for the carrier to drop; the morse sender acknowledges
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pending_ff <= 1'b0;
    end else if (accept || (str_end_ff && str_valid_ff) ||
                 (strobe && state_ff == S_DAT_HI && digit == DIG_STAR && fn_ff == FN_TXCTL) ||
                 (strobe && state_ff == S_DAT_LO && fn_ff == FN_CLRPERM &&
                  hi_ff == 4'h0 && digit == DIG_STAR)) begin
      pending_ff <= 1'b1;
    end else if (i_ok_done && !carrier) begin
      pending_ff <= 1'b0;
    end
  end

  assign o_ok_req = pending_ff && !carrier;

  assign o_main_tx_inhibit = f00_ff[0];
  assign o_link_tx_inhibit = f00_ff[0] | f00_ff[1];
  assign o_timeout_disable = f00_ff[2];
  assign o_roger_suppress = f00_ff[1] | relay_raw_ff[2];
  assign o_extra_tail_beeps = f00_ff[2];
  assign o_sec_port_pulse = (pulse_ff != 32'h0);

  assign o_port_opts = '{port_raw_ff[0], port_raw_ff[2:1], port_raw_ff[3],
                         port_raw_ff[4], port_raw_ff[5], port_raw_ff[6]};
  assign o_sec_tail_callsign = port_raw_ff[0];
  assign o_relay_opts = '{relay_raw_ff[0], relay_raw_ff[1], relay_raw_ff[2],
                          relay_raw_ff[3], relay_raw_ff[4], relay_raw_ff[5]};
  assign o_tone_opts = '{tone_raw_ff[0], tone_raw_ff[1], tone_raw_ff[2],
                         tone_raw_ff[3], tone_raw_ff[4], tone_raw_ff[5]};

  assign o_str_byte = str_byte_ff;
  assign o_str_valid = str_valid_ff;
  assign o_str_end = str_end_ff;
  assign o_str_callsign = str_call_ff;

endmodule // dtmf_remote_command_parser

//--- rtl/remote_cmd_pkg.sv
/*
  constants and carrier types for the remote command parser.
  assumes a 20 mhz system clock and a key decoder with a valid-tone strobe.
*/
package remote_cmd_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned GAP_MS = 5000;
  localparam int unsigned GAP_CYCLES = CLK_HZ / 1000 * GAP_MS;
  localparam int unsigned PULSE_MS = 500;
  localparam int unsigned PULSE_CYCLES = CLK_HZ / 1000 * PULSE_MS;
  localparam int unsigned PASS_LEN = 3;

  // function addresses
  localparam logic [7:0] FN_TXCTL = 8'h00;
  localparam logic [7:0] FN_PORT = 8'h01;
  localparam logic [7:0] FN_RELAY = 8'h02;
  localparam logic [7:0] FN_CTCSS = 8'h03;
  localparam logic [7:0] FN_CTDLY = 8'h04;
  localparam logic [7:0] FN_MUTEDLY = 8'h05;
  localparam logic [7:0] FN_CALLINT = 8'h06;
  localparam logic [7:0] FN_TIMEOUT = 8'h07;
  localparam logic [7:0] FN_TAIL = 8'h08;
  localparam logic [7:0] FN_MSGINT = 8'h09;
  localparam logic [7:0] FN_POSTTAIL = 8'h0a;
  localparam logic [7:0] FN_SPEED = 8'h0b;
  localparam logic [7:0] FN_CALLSIGN = 8'h0c;
  localparam logic [7:0] FN_MESSAGE = 8'h0d;
  localparam logic [7:0] FN_CLRPERM = 8'h0e;
  localparam logic [7:0] FN_FREQ = 8'h10;
  localparam logic [7:0] FN_VMAIN = 8'h11;
  localparam logic [7:0] FN_VLINK = 8'h12;

  localparam logic [7:0] STR_END = 8'hff;
  localparam logic [3:0] DIG_STAR = 4'he;

  // data limits
  localparam logic [7:0] MAX_MINS = 8'h4b;
  localparam logic [7:0] MAX_TAIL = 8'h96;
  localparam logic [7:0] MAX_SPEED = 8'h13;
  localparam logic [7:0] MIN_FREQ = 8'h05;
  localparam logic [7:0] MAX_FREQ = 8'h7f;
  localparam logic [7:0] MIN_VOLT = 8'h72;
  localparam logic [7:0] MAX_VOLT = 8'h8c;

  // reset values
  localparam logic [7:0] RST_CTDLY = 8'h0a;
  localparam logic [7:0] RST_MUTEDLY = 8'h00;
  localparam logic [7:0] RST_CALLINT = 8'h0a;
  localparam logic [7:0] RST_TIMEOUT = 8'h03;
  localparam logic [7:0] RST_TAIL = 8'h0a;
  localparam logic [7:0] RST_MSGINT = 8'h1d;
  localparam logic [7:0] RST_POSTTAIL = 8'h0f;
  localparam logic [7:0] RST_SPEED = 8'h04;
  localparam logic [7:0] RST_FREQ = 8'h76;
  localparam logic [7:0] RST_VMAIN = 8'h73;
  localparam logic [7:0] RST_VLINK = 8'h77;
  localparam logic [7:0] RST_OPT = 8'h00;

  typedef struct packed {
    logic gateway;
    logic [1:0] id_mode;
    logic burst_access;
    logic ext_tail;
    logic sec_port_en;
    logic no_callsign;
  } port_opts_t;

  typedef struct packed {
    logic relay_main;
    logic relay_link;
    logic no_roger;
    logic ext_rx_nomute;
    logic sec_rx_mute;
    logic volt_telemetry;
  } relay_opts_t;

  typedef struct packed {
    logic link_needs_tone;
    logic any_needs_tone;
    logic gate_needs_tone;
    logic hour_timeout;
    logic ext_mode;
    logic tone_or_mute;
  } tone_opts_t;

  typedef struct packed {
    logic [7:0] ctcss_delay;
    logic [7:0] mute_delay;
    logic [7:0] call_interval;
    logic [7:0] timeout_mins;
    logic [7:0] tail_tenths;
    logic [7:0] msg_interval;
    logic [7:0] post_tail;
    logic [7:0] morse_speed;
    logic [7:0] morse_freq;
    logic [7:0] volt_main;
    logic [7:0] volt_link;
  } timers_t;
endpackage

//--- verif/dtmf_remote_command_parser_bench.sv
/*
  bench for the remote command parser: keys go through a decoder model and
  every output is compared with an array model. assumes short gap and pulse.
*/
module dtmf_remote_command_parser_bench
  import remote_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned G_LEN = 200;
  localparam int unsigned P_LEN = 50;
  localparam logic [11:0] PW = 12'h4a7;
  logic i_clk = 1'b0;
  logic i_resetn, i_carrier, i_ok_done, i_key_valid, o_ok_req, o_main_tx_inhibit;
  logic o_link_tx_inhibit, o_timeout_disable, o_roger_suppress, o_extra_tail_beeps;
  logic o_sec_port_pulse, o_sec_tail_callsign, o_str_callsign, o_str_valid, o_str_end;
  logic [3:0] i_key_code;
  logic [7:0] o_str_byte;
  port_opts_t o_port_opts;
  relay_opts_t o_relay_opts;
  tone_opts_t o_tone_opts;
  timers_t o_timers;
  logic [7:0] hi[11] = '{8'h4b, 8'hff, 8'h4b, 8'h4b, 8'h96, 8'h4b, 8'h13, 8'h13, 8'h7f,
    8'h8c, 8'h8c};
  logic [7:0] et[11] = '{8'h0a, 8'h00, 8'h0a, 8'h03, 8'h0a, 8'h1d, 8'h0f, 8'h04, 8'h76,
    8'h73, 8'h77};
  logic [7:0] eo[3] = '{8'h00, 8'h00, 8'h00};
  logic em = 1'b0;
  logic el = 1'b0;
  logic eto = 1'b0;
  logic [9:0] sq[$];
  logic [9:0] eq[$];
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  int pulse_cnt = 0;
  always #25 i_clk = ~i_clk;
  key_decoder_model dec (.i_clk(i_clk), .o_code(i_key_code), .o_valid(i_key_valid));
  dtmf_remote_command_parser #(.GAP_LIMIT(G_LEN), .PULSE_LEN(P_LEN), .PASSWORD(PW)) uut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_key_code(i_key_code), .i_key_valid(i_key_valid),
    .i_carrier(i_carrier), .i_ok_done(i_ok_done), .o_ok_req(o_ok_req),
    .o_main_tx_inhibit(o_main_tx_inhibit), .o_link_tx_inhibit(o_link_tx_inhibit),
    .o_timeout_disable(o_timeout_disable), .o_roger_suppress(o_roger_suppress),
    .o_extra_tail_beeps(o_extra_tail_beeps), .o_sec_port_pulse(o_sec_port_pulse),
    .o_port_opts(o_port_opts), .o_sec_tail_callsign(o_sec_tail_callsign),
    .o_relay_opts(o_relay_opts), .o_tone_opts(o_tone_opts), .o_timers(o_timers),
    .o_str_byte(o_str_byte), .o_str_callsign(o_str_callsign), .o_str_valid(o_str_valid),
    .o_str_end(o_str_end));
  // sampled at the falling edge, where the outputs have settled
  always @(negedge i_clk) begin
    cyc++;
    if (o_sec_port_pulse === 1'b1) pulse_cnt++;
    if (o_str_valid === 1'b1) sq.push_back({o_str_end, o_str_callsign, o_str_byte});
    if (cyc == 30000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic close_out();
    if (miscompares == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [87:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // data bit 0 lands in the first field, which a packed struct puts at the top
  function automatic logic [6:0] fl(input logic [7:0] d, input bit p);
    for (int i = 0; i < 7; i++) fl[6-i] = d[i];
    if (p) fl[5:4] = d[2:1];
  endfunction
  task automatic compare_all();
    logic [87:0] tv;
    for (int i = 0; i < 11; i++) tv[87-8*i -: 8] = et[i];
    @(negedge i_clk);
    check("timers", o_timers, tv);
    check("port", o_port_opts, fl(eo[0], 1));
    check("relay", o_relay_opts, fl(eo[1], 0) >> 1);
    check("tone", o_tone_opts, fl(eo[2], 0) >> 1);
    check("gate", o_sec_tail_callsign, eo[0][0]);
    check("main", o_main_tx_inhibit, em);
    check("link", o_link_tx_inhibit, el);
    check("timer", o_timeout_disable, eto);
    check("beeps", o_extra_tail_beeps, eto);
    check("roger", o_roger_suppress, el & ~em | eo[1][2]);
  endtask
  task automatic put(input logic [7:0] b);
    dec.press(b[7:4]);
    dec.press(b[3:0]);
  endtask
  task automatic head(input logic [11:0] pw, input logic [7:0] f);
    @(posedge i_clk);
    i_carrier <= 1'b1;
    dec.press(DIG_STAR);
    for (int i = 2; i >= 0; i--) dec.press(pw[4*i +: 4]);
    put(f);
  endtask
  task automatic ack(input bit ok);
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
    check("ok_early", o_ok_req, 1'b0);
    @(posedge i_clk);
    i_carrier <= 1'b0;
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
    check("ok_req", o_ok_req, ok);
    @(posedge i_clk);
    i_ok_done <= ok;
    @(posedge i_clk);
    i_ok_done <= 1'b0;
    @(negedge i_clk);
    check("ok_clear", o_ok_req, 1'b0);
  endtask
  task automatic cmd(input logic [7:0] f, d, input bit ok);
    head(PW, f);
    put(d);
    ack(ok);
  endtask
  initial begin
    logic [7:0] v;
    int n;
    i_resetn = 1'b0;
    i_carrier = 1'b0;
    i_ok_done = 1'b0;
    void'($urandom(39));
    repeat (12) @(posedge i_clk);
    i_resetn <= 1'b1;
    compare_all();
    cmd(8'h00, 8'h01, 1'b1);
    em = 1'b1;
    el = 1'b1;
    compare_all();
    @(posedge i_clk);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    em = 1'b0;
    el = 1'b0;
    compare_all();
    for (int i = 0; i < 11; i++) begin
      v = (i == 8 ? 8'h05 : i > 8 ? 8'h72 : 8'h00);
      v = v + 8'($urandom % (hi[i] - v + 1));
      cmd(i < 8 ? 8'h04 + 8'(i) : 8'h08 + 8'(i), v, 1'b1);
      et[i] = v;
      compare_all();
      if (hi[i] != 8'hff) cmd(i < 8 ? 8'h04 + 8'(i) : 8'h08 + 8'(i), hi[i] + 8'h01, 1'b0);
      compare_all();
    end
    for (int f = 1; f < 4; f++) repeat (2) begin
      v = 8'($urandom % 128);
      cmd(8'(f), v, 1'b1);
      eo[f-1] = v;
      compare_all();
    end
    cmd(8'h02, 8'h80, 1'b0);
    for (int k = 0; k < 5; k++) begin
      v = (k % 2) ? 8'h00 : 8'(k / 2 + 1);
      cmd(8'h00, v, 1'b1);
      em = (v == 8'h01);
      el = (v == 8'h01 || v == 8'h02);
      eto = (v == 8'h03);
      compare_all();
    end
    head(PW, 8'h00);
    dec.press(DIG_STAR);
    ack(1'b1);
    eto = 1'b0;
    compare_all();
    cmd(8'h00, 8'h01, 1'b1);
    head(PW, 8'h0e);
    put(8'h0e);
    ack(1'b1);
    compare_all();
    cmd(8'h00, 8'h05, 1'b0);
    cmd(8'h00, 8'h04, 1'b1);
    repeat (P_LEN) @(posedge i_clk);
    check("pulse", pulse_cnt, P_LEN);
    head(PW ^ 12'h001, 8'h04);
    put(8'h01);
    ack(1'b0);
    head(PW, 8'h04);
    repeat (G_LEN + 20) @(posedge i_clk);
    put(8'h02);
    ack(1'b0);
    cmd(8'h0f, 8'h00, 1'b0);
    compare_all();
    for (int f = 12; f < 14; f++) begin
      head(PW, 8'(f));
      n = 1 + $urandom % 3;
      for (int k = 0; k < n; k++) begin
        v = 8'($urandom % 255);
        put(v);
        eq.push_back({1'b0, f == 12, v});
      end
      put(STR_END);
      eq.push_back({1'b1, f == 12, STR_END});
      ack(1'b1);
    end
    check("str_count", sq.size(), eq.size());
    foreach (eq[k]) check("str_byte", sq[k], eq[k]);
    close_out();
  end
endmodule // dtmf_remote_command_parser_bench

//--- verif/dtmf_remote_command_parser_sva.sv
/*
  checker for the remote command parser outputs.
  assumes it is bound to the parser top with the same pulse length.
*/
module dtmf_remote_command_parser_sva
  import remote_cmd_pkg::*;
#(
  parameter int unsigned PULSE_LEN = 50
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // inputs
  input wire logic i_key_valid,
  input wire logic i_carrier,
  input wire logic i_ok_done,
  // outputs
  input wire logic o_ok_req,
  input wire logic o_main_tx_inhibit,
  input wire logic o_link_tx_inhibit,
  input wire logic o_timeout_disable,
  input wire logic o_roger_suppress,
  input wire logic o_extra_tail_beeps,
  input wire logic o_sec_port_pulse,
  input wire port_opts_t o_port_opts,
  input wire logic o_sec_tail_callsign,
  input wire relay_opts_t o_relay_opts,
  input wire timers_t o_timers,
  input wire logic [7:0] o_str_byte,
  input wire logic o_str_valid,
  input wire logic o_str_end
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  int unsigned pulse_cnt_ff;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pulse_cnt_ff <= 0;
    end else begin
      pulse_cnt_ff <= o_sec_port_pulse ? pulse_cnt_ff + 1 : 0;
    end
  end
  a_extra_beeps: assert property (o_extra_tail_beeps == o_timeout_disable)
    else $error("extra beeps differ from timer disable");
  a_gate_tail: assert property (o_sec_tail_callsign == o_port_opts.gateway)
    else $error("tail and callsign differ from gateway bit");
  a_roger_cut: assert property ((o_relay_opts.no_roger || (o_link_tx_inhibit &&
    !o_main_tx_inhibit)) |-> o_roger_suppress)
    else $error("roger beep not suppressed");
  a_main_link: assert property (o_main_tx_inhibit |-> o_link_tx_inhibit)
    else $error("main inhibit without link inhibit");
  a_ok_carrier: assert property (i_carrier [*3] |-> !o_ok_req)
    else $error("ok requested while carrier present");
  a_ok_drop: assert property (o_ok_req && i_ok_done |=> !o_ok_req)
    else $error("ok request held after done");
  a_pulse_len: assert property ($fell(o_sec_port_pulse) |-> pulse_cnt_ff == PULSE_LEN)
    else $error("secondary port pulse length wrong");
  a_str_end: assert property (o_str_end |-> o_str_valid && o_str_byte == STR_END)
    else $error("string end without end byte");
  a_str_pulse: assert property (o_str_valid |=> !o_str_valid)
    else $error("string strobe longer than one cycle");
  a_timer_cause: assert property (!$stable(o_timers) |->
    $past(i_key_valid, 3) || $past(i_key_valid, 4))
    else $error("settings changed without a key");
endmodule // dtmf_remote_command_parser_sva
bind dtmf_remote_command_parser dtmf_remote_command_parser_sva #(.PULSE_LEN(PULSE_LEN)) chk (
  .i_clk, .i_resetn, .i_key_valid, .i_carrier, .i_ok_done, .o_ok_req, .o_main_tx_inhibit,
  .o_link_tx_inhibit, .o_timeout_disable, .o_roger_suppress, .o_extra_tail_beeps,
  .o_sec_port_pulse, .o_port_opts, .o_sec_tail_callsign, .o_relay_opts, .o_timers,
  .o_str_byte, .o_str_valid, .o_str_end
);

//--- verif/key_decoder_model.sv
/*
  key decoder model: turns a digit value into a raw tone code and a strobe.
  assumes the parser samples the code only while the strobe is high.
*/
module key_decoder_model (
  // clock
  input wire logic i_clk,
  // to the parser
  output logic [3:0] o_code,
  output logic o_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  function automatic logic [3:0] enc(input logic [3:0] d);
    case (d)
      4'h0: return 4'ha;
      4'ha, 4'hb, 4'hc: return d + 4'h3;
      4'hd: return 4'h0;
      4'he, 4'hf: return d - 4'h3;
      default: return d;
    endcase
  endfunction
  initial begin
    o_code = 4'h0;
    o_valid = 1'b0;
  end
  // idle code is inverted so a stale value can never pass as the next key
  task automatic press(input logic [3:0] d);
    @(posedge i_clk);
    o_code <= enc(d);
    o_valid <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_valid <= 1'b0;
    o_code <= ~enc(d);
    repeat (4) @(posedge i_clk);
  endtask
endmodule // key_decoder_model
